// >>> hdl/spcr_field_join.sv
// module: joins the split profile fields back into whole values
`timescale 1ns/100ps
module spcr_field_join
  import spcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // stored words
  input wire logic [SPCR_WORDS*SPCR_DW-1:0] words,
  // joined fields
  output spcr_pkg::spcr_mode_t mode_q,
  output logic [7:0] on1_q,
  output logic [7:0] off1_q,
  output logic [7:0] clamp1_q,
  output logic [7:0] on2_q,
  output logic [7:0] off2_q,
  output logic [7:0] clamp2_q,
  output logic [39:0] in_bk_q,
  output logic [7:0] toff1_q,
  output logic [7:0] tclamp1_q,
  output logic [7:0] sbk1_q,
  output logic [7:0] sbk2_q,
  output logic [13:0] max_speed_q
);
  logic [31:0] w1, w2, w3, w4, w5, wl;
  logic [7:0] on1_d, off1_d, clamp1_d, on2_d, off2_d, clamp2_d;
  logic [7:0] toff1_d, tclamp1_d, sbk1_d, sbk2_d;
  logic [39:0] in_bk_d;
  logic [13:0] max_speed_d;
  spcr_mode_t mode_d;

  assign wl = words[SPCR_SLOT_LIMIT*SPCR_DW+:SPCR_DW];
  assign w1 = words[SPCR_SLOT_W1*SPCR_DW+:SPCR_DW];
  assign w2 = words[SPCR_SLOT_W2*SPCR_DW+:SPCR_DW];
  assign w3 = words[SPCR_SLOT_W3*SPCR_DW+:SPCR_DW];
  assign w4 = words[SPCR_SLOT_W4*SPCR_DW+:SPCR_DW];
  assign w5 = words[SPCR_SLOT_W5*SPCR_DW+:SPCR_DW];

  always_comb begin
    mode_d = spcr_mode_t'(w1[SPCR_MODE_LSB+:2]);
    on1_d = w1[SPCR_ON1_LSB+:8];
    off1_d = w1[SPCR_OFF1_LSB+:8];
    clamp1_d = w1[SPCR_CLAMP1_LSB+:8];
    in_bk_d[7:0] = {w1[SPCR_BK1_HI_LSB+:5], w2[SPCR_BK1_LO_LSB+:3]};
    in_bk_d[15:8] = w2[SPCR_BK2_LSB+:8];
    in_bk_d[23:16] = w2[SPCR_BK3_LSB+:8];
    in_bk_d[31:24] = w2[SPCR_BK4_LSB+:8];
    in_bk_d[39:32] = {w2[SPCR_BK5_HI_LSB+:4], w3[SPCR_BK5_LO_LSB+:4]};
    on2_d = w3[SPCR_ON2_LSB+:8];
    off2_d = w3[SPCR_OFF2_LSB+:8];
    clamp2_d = w3[SPCR_CLAMP2_LSB+:8];
    toff1_d = w4[SPCR_TOFF1_LSB+:8];
    tclamp1_d = w4[SPCR_TCLAMP1_LSB+:8];
    sbk1_d = w4[SPCR_SBK1_LSB+:8];
    sbk2_d = {w4[SPCR_SBK2_HI_LSB+:7], w5[SPCR_SBK2_LO_LSB]};
    max_speed_d = wl[SPCR_MAXSPD_LSB+:14];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= SPCR_MODE_SPEED_REF;
      on1_q <= 8'h00;
      off1_q <= 8'h00;
      clamp1_q <= 8'h00;
      on2_q <= 8'h00;
      off2_q <= 8'h00;
      clamp2_q <= 8'h00;
      in_bk_q <= 40'h00_0000_0000;
      toff1_q <= 8'h00;
      tclamp1_q <= 8'h00;
      sbk1_q <= 8'h00;
      sbk2_q <= 8'h00;
      max_speed_q <= 14'h0000;
    end else begin
      mode_q <= mode_d;
      on1_q <= on1_d;
      off1_q <= off1_d;
      clamp1_q <= clamp1_d;
      on2_q <= on2_d;
      off2_q <= off2_d;
      clamp2_q <= clamp2_d;
      in_bk_q <= in_bk_d;
      toff1_q <= toff1_d;
      tclamp1_q <= tclamp1_d;
      sbk1_q <= sbk1_d;
      sbk2_q <= sbk2_d;
      max_speed_q <= max_speed_d;
    end
  end
endmodule

// >>> hdl/spcr_pkg.sv
// package: map, field layout and reset values of the speed profile bank
package spcr_pkg;
  // ****************************************************************
  // bus and map
  // ****************************************************************
  localparam int SPCR_AW = 12;
  localparam int SPCR_DW = 32;
  localparam int SPCR_WORDS = 6;
  localparam int SPCR_SW = 3;
  // register indices; the byte address is four times the index
  localparam logic [9:0] SPCR_IDX_LIMIT = 10'h08e;
  localparam logic [9:0] SPCR_IDX_W1 = 10'h094;
  localparam logic [9:0] SPCR_IDX_W2 = 10'h096;
  localparam logic [9:0] SPCR_IDX_W3 = 10'h098;
  localparam logic [9:0] SPCR_IDX_W4 = 10'h09a;
  localparam logic [9:0] SPCR_IDX_W5 = 10'h09c;
  // storage slots
  localparam logic [2:0] SPCR_SLOT_LIMIT = 3'h0;
  localparam logic [2:0] SPCR_SLOT_W1 = 3'h1;
  localparam logic [2:0] SPCR_SLOT_W2 = 3'h2;
  localparam logic [2:0] SPCR_SLOT_W3 = 3'h3;
  localparam logic [2:0] SPCR_SLOT_W4 = 3'h4;
  localparam logic [2:0] SPCR_SLOT_W5 = 3'h5;
  // every word clears to zero; undefined fields get a defined value
  localparam logic [31:0] SPCR_RST_WORD = 32'h0000_0000;
  // ****************************************************************
  // field positions (lsb of each field)
  // ****************************************************************
  localparam int SPCR_MAXSPD_LSB = 0;
  localparam int SPCR_MODE_LSB = 29;
  localparam int SPCR_ON1_LSB = 21;
  localparam int SPCR_OFF1_LSB = 13;
  localparam int SPCR_CLAMP1_LSB = 5;
  localparam int SPCR_BK1_HI_LSB = 0;
  localparam int SPCR_BK1_LO_LSB = 28;
  localparam int SPCR_BK2_LSB = 20;
  localparam int SPCR_BK3_LSB = 12;
  localparam int SPCR_BK4_LSB = 4;
  localparam int SPCR_BK5_HI_LSB = 0;
  localparam int SPCR_BK5_LO_LSB = 27;
  localparam int SPCR_ON2_LSB = 19;
  localparam int SPCR_OFF2_LSB = 11;
  localparam int SPCR_CLAMP2_LSB = 3;
  localparam int SPCR_TOFF1_LSB = 23;
  localparam int SPCR_TCLAMP1_LSB = 15;
  localparam int SPCR_SBK1_LSB = 7;
  localparam int SPCR_SBK2_HI_LSB = 0;
  localparam int SPCR_SBK2_LO_LSB = 30;
  localparam logic [21:0] SPCR_FULL_SCALE = 22'h0000ff;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    SPCR_MODE_SPEED_REF = 2'h0,
    SPCR_MODE_LINEAR = 2'h1,
    SPCR_MODE_STAIRCASE = 2'h2,
    SPCR_MODE_FWD_REV = 2'h3
  } spcr_mode_t;
  typedef enum logic [2:0] {
    SPCR_ST_IDLE = 3'b001,
    SPCR_ST_WAIT = 3'b010,
    SPCR_ST_DONE = 3'b100
  } spcr_state_t;
endpackage

// >>> hdl/spcr_regs.sv
// module: speed profile configuration bank, apb slave and field outputs
`timescale 1ns/100ps
// How it works
// - bits 30-29 of word one pick speed-reference, linear, staircase or forward-reverse.
// - first turn-on duty threshold is word one bits 28-21, scaled over 255.
// - first turn-off duty threshold is word one bits 20-13, scaled over 255.
// - first clamp duty threshold is word one bits 12-5, scaled over 255.
// - input breakpoint one joins word one bits 4-0 with word two bits 30-28.
// - input breakpoints two to four sit in word two at 27-20, 19-12, 11-4.
// - input breakpoint five joins word two bits 3-0 with word three bits 30-27.
// - second turn-on duty threshold is word three bits 26-19.
// - second turn-off duty threshold is word three bits 18-11.
// - second clamp duty threshold is word three bits 10-3, its own value scaled.
// - first turn-off target speed is word four bits 30-23, share of maximum speed.
// - first clamp target speed is word four bits 22-15, share of maximum speed.
// - speed breakpoint one is word four bits 14-7, share of maximum speed.
// - speed breakpoint two takes its seven upper bits from word four bits 6-0.
// - its lowest bit is word five bit 30; the whole is scaled against maximum speed.
// - maximum speed is a 14-bit electrical hertz field in the loop word.
module spcr_regs
  import spcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spcr_pkg::SPCR_AW-1:0] paddr,
  input wire logic [spcr_pkg::SPCR_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [spcr_pkg::SPCR_DW-1:0] prdata,
  output logic pslverr,
  // profile mode
  output spcr_pkg::spcr_mode_t profile_mode,
  output logic [3:0] profile_mode_sel,
  // input duty thresholds
  output logic [7:0] input_on_threshold_1,
  output logic [7:0] input_off_threshold_1,
  output logic [7:0] input_clamp_threshold_1,
  output logic [7:0] input_on_threshold_2,
  output logic [7:0] input_off_threshold_2,
  output logic [7:0] input_clamp_threshold_2,
  // input breakpoints one to five
  output logic [7:0] input_bkpt_1,
  output logic [7:0] input_bkpt_2,
  output logic [7:0] input_bkpt_3,
  output logic [7:0] input_bkpt_4,
  output logic [7:0] input_bkpt_5,
  // target speeds as raw shares of full scale
  output logic [7:0] turnoff_target_1,
  output logic [7:0] clamp_target_1,
  output logic [7:0] speed_bkpt_1,
  output logic [7:0] speed_bkpt_2,
  // target speeds in electrical hertz
  output logic [13:0] max_speed_hz,
  output logic [13:0] turnoff_speed_hz_1,
  output logic [13:0] clamp_speed_hz_1,
  output logic [13:0] bkpt_speed_hz_1,
  output logic [13:0] bkpt_speed_hz_2
);
  import spcr_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // maps a byte address onto a storage slot; hit is the top bit
  function automatic logic [3:0] slot_of(input logic [SPCR_AW-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a[1:0] == 2'h0) begin
      case (a[SPCR_AW-1:2])
        SPCR_IDX_LIMIT: r = {1'b1, SPCR_SLOT_LIMIT};
        SPCR_IDX_W1: r = {1'b1, SPCR_SLOT_W1};
        SPCR_IDX_W2: r = {1'b1, SPCR_SLOT_W2};
        SPCR_IDX_W3: r = {1'b1, SPCR_SLOT_W3};
        SPCR_IDX_W4: r = {1'b1, SPCR_SLOT_W4};
        SPCR_IDX_W5: r = {1'b1, SPCR_SLOT_W5};
        default: r = 4'h0;
      endcase
    end
    return r;
  endfunction

  // share of full scale times maximum speed; result never exceeds max
  function automatic logic [13:0] scale(input logic [7:0] v, input logic [13:0] m);
    logic [21:0] p;
    p = 22'(v) * 22'(m);
    return 14'(p / SPCR_FULL_SCALE);
  endfunction

  // one-hot view of the mode code for the profile logic
  function automatic logic [3:0] onehot_of(input spcr_mode_t m);
    logic [3:0] r;
    r = 4'h1;
    case (m)
      SPCR_MODE_SPEED_REF: r = 4'h1;
      SPCR_MODE_LINEAR: r = 4'h2;
      SPCR_MODE_STAIRCASE: r = 4'h4;
      SPCR_MODE_FWD_REV: r = 4'h8;
      default: r = 4'h1;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // apb transfer sequencing
  // ****************************************************************
  spcr_state_t state_q;
  spcr_state_t state_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [SPCR_DW-1:0] prdata_q;
  logic [SPCR_DW-1:0] prdata_d;
  logic [3:0] dec;
  logic wr_en;
  logic [SPCR_DW-1:0] rd_data;
  logic [SPCR_WORDS*SPCR_DW-1:0] words;

  // decode straight from the held address; the master keeps it stable
  assign dec = slot_of(paddr);

  // ****************************************************************
  // transfer capture
  // ****************************************************************
  // the decode is taken once, at setup; the answer and the write then
  // no longer lean on a long path from the address pins
  logic hit_q;
  logic hit_d;
  logic [SPCR_SW-1:0] slot_q;
  logic [SPCR_SW-1:0] slot_d;

  always_comb begin
    hit_d = hit_q;
    slot_d = slot_q;
    if (state_q == SPCR_ST_IDLE && psel && !penable) begin
      hit_d = dec[3];
      slot_d = dec[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hit_q <= 1'b0;
      slot_q <= '0;
    end else begin
      hit_q <= hit_d;
      slot_q <= slot_d;
    end
  end

  always_comb begin
    state_d = state_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = '0;
    wr_en = 1'b0;
    case (state_q)
      SPCR_ST_IDLE: begin
        if (psel && !penable) begin
          state_d = SPCR_ST_WAIT;
        end
      end
      // one wait cycle lets the storage read settle into its register
      SPCR_ST_WAIT: begin
        if (psel && penable) begin
          state_d = SPCR_ST_DONE;
          pready_d = 1'b1;
          pslverr_d = !hit_q;
          prdata_d = (hit_q && !pwrite) ? rd_data : '0;
        end else begin
          state_d = SPCR_ST_IDLE;
        end
      end
      // writes land at the same edge at which the master sees pready
      SPCR_ST_DONE: begin
        state_d = SPCR_ST_IDLE;
        wr_en = psel && penable && pwrite && hit_q;
      end
      default: begin
        state_d = SPCR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= SPCR_ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      state_q <= state_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ****************************************************************
  // storage
  // ****************************************************************
  // parity and reserved bits are kept as plain read/write storage
  spcr_word_mem #(
    .WORDS(SPCR_WORDS),
    .DW(SPCR_DW),
    .SW(SPCR_SW),
    .RST_VAL(SPCR_RST_WORD)
  ) u_mem (
    .clk(clk),
    .srst(srst),
    .wr_en(wr_en),
    .wr_slot(slot_q),
    .wr_strb(pstrb),
    .wr_data(pwdata),
    .rd_slot(dec[2:0]),
    .rd_data_q(rd_data),
    .words(words)
  );

  // ****************************************************************
  // field joining
  // ****************************************************************
  logic [39:0] in_bk;

  spcr_field_join u_join (
    .clk(clk),
    .srst(srst),
    .words(words),
    .mode_q(profile_mode),
    .on1_q(input_on_threshold_1),
    .off1_q(input_off_threshold_1),
    .clamp1_q(input_clamp_threshold_1),
    .on2_q(input_on_threshold_2),
    .off2_q(input_off_threshold_2),
    .clamp2_q(input_clamp_threshold_2),
    .in_bk_q(in_bk),
    .toff1_q(turnoff_target_1),
    .tclamp1_q(clamp_target_1),
    .sbk1_q(speed_bkpt_1),
    .sbk2_q(speed_bkpt_2),
    .max_speed_q(max_speed_hz)
  );

  assign input_bkpt_1 = in_bk[7:0];
  assign input_bkpt_2 = in_bk[15:8];
  assign input_bkpt_3 = in_bk[23:16];
  assign input_bkpt_4 = in_bk[31:24];
  assign input_bkpt_5 = in_bk[39:32];

  // ****************************************************************
  // mode decode and speed scaling
  // ****************************************************************
  logic [3:0] mode_sel_q;
  logic [3:0] mode_sel_d;
  logic [13:0] toff_hz_q;
  logic [13:0] toff_hz_d;
  logic [13:0] tclamp_hz_q;
  logic [13:0] tclamp_hz_d;
  logic [13:0] sbk1_hz_q;
  logic [13:0] sbk1_hz_d;
  logic [13:0] sbk2_hz_q;
  logic [13:0] sbk2_hz_d;

  // scaled speeds lag the raw fields by one cycle; a full divider
  // is traded here for one slow path, settings change rarely
  always_comb begin
    mode_sel_d = onehot_of(profile_mode);
    toff_hz_d = scale(turnoff_target_1, max_speed_hz);
    tclamp_hz_d = scale(clamp_target_1, max_speed_hz);
    sbk1_hz_d = scale(speed_bkpt_1, max_speed_hz);
    sbk2_hz_d = scale(speed_bkpt_2, max_speed_hz);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_sel_q <= 4'h1;
      toff_hz_q <= 14'h0000;
      tclamp_hz_q <= 14'h0000;
      sbk1_hz_q <= 14'h0000;
      sbk2_hz_q <= 14'h0000;
    end else begin
      mode_sel_q <= mode_sel_d;
      toff_hz_q <= toff_hz_d;
      tclamp_hz_q <= tclamp_hz_d;
      sbk1_hz_q <= sbk1_hz_d;
      sbk2_hz_q <= sbk2_hz_d;
    end
  end

  assign profile_mode_sel = mode_sel_q;
  assign turnoff_speed_hz_1 = toff_hz_q;
  assign clamp_speed_hz_1 = tclamp_hz_q;
  assign bkpt_speed_hz_1 = sbk1_hz_q;
  assign bkpt_speed_hz_2 = sbk2_hz_q;
endmodule

// >>> hdl/spcr_word_mem.sv
// module: word storage of the bank with byte writes and registered read
`timescale 1ns/100ps
module spcr_word_mem #(
  parameter int WORDS = 6,
  parameter int DW = 32,
  parameter int SW = 3,
  parameter logic [DW-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // write port
  input wire logic wr_en,
  input wire logic [SW-1:0] wr_slot,
  input wire logic [DW/8-1:0] wr_strb,
  input wire logic [DW-1:0] wr_data,
  // read port
  input wire logic [SW-1:0] rd_slot,
  output logic [DW-1:0] rd_data_q,
  // all words for the field logic
  output logic [WORDS*DW-1:0] words
);
  logic [DW-1:0] mem_q [WORDS];
  logic [DW-1:0] mem_d [WORDS];
  logic [DW-1:0] rd_data_d;

  always_comb begin
    rd_data_d = '0;
    for (int i = 0; i < WORDS; i++) begin
      for (int b = 0; b < DW / 8; b++) begin
        if (wr_en && wr_slot == SW'(i) && wr_strb[b]) begin
          mem_d[i][8*b+:8] = wr_data[8*b+:8];
        end else begin
          mem_d[i][8*b+:8] = mem_q[i][8*b+:8];
        end
      end
      if (rd_slot == SW'(i)) begin
        rd_data_d = mem_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < WORDS; i++) begin
      mem_q[i] <= srst ? RST_VAL : mem_d[i];
    end
    rd_data_q <= srst ? '0 : rd_data_d;
  end

  for (genvar g = 0; g < WORDS; g++) begin : g_flat
    assign words[g*DW+:DW] = mem_q[g];
  end
endmodule

// >>> sim/spcr_regs_asserts.sv
// checker: apb and field output properties of the speed profile bank
`timescale 1ns/100ps
module spcr_regs_asserts
  import spcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spcr_pkg::SPCR_AW-1:0] paddr,
  input wire logic [spcr_pkg::SPCR_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [spcr_pkg::SPCR_DW-1:0] prdata,
  input wire logic pslverr,
  // watched fields
  input wire spcr_pkg::spcr_mode_t profile_mode,
  input wire logic [3:0] profile_mode_sel,
  input wire logic [7:0] input_on_threshold_1,
  input wire logic [7:0] input_clamp_threshold_2,
  input wire logic [7:0] turnoff_target_1,
  input wire logic [7:0] speed_bkpt_2,
  input wire logic [13:0] max_speed_hz,
  input wire logic [13:0] turnoff_speed_hz_1,
  input wire logic [13:0] bkpt_speed_hz_2
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic wr_ok;
  // only full-word writes, so every field of the word is known afterwards
  assign wr_ok = psel && penable && pready && pwrite && !pslverr && pstrb == 4'hf;
  // ****************************************************************
  // properties
  // ****************************************************************
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_time: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("ready late after access");
  a_err_clean: assert property (pslverr |-> pready && prdata == '0)
    else $error("error without ready or with data");
  a_data_quiet: assert property (!pready |-> prdata == '0)
    else $error("read data outside ready cycle");
  a_bad_refused: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_mode_onehot: assert property (1'b1 |=> profile_mode_sel == 4'h1 << $past(profile_mode))
    else $error("mode select does not follow mode");
  a_on1_join: assert property (wr_ok && paddr == 12'h250 |-> ##2 input_on_threshold_1 == $past(pwdata[28:21], 2))
    else $error("on threshold one wrong after write");
  a_clamp2_join: assert property (wr_ok && paddr == 12'h260 |-> ##2 input_clamp_threshold_2 == $past(pwdata[10:3], 2))
    else $error("clamp threshold two wrong after write");
  a_sbk2_join: assert property (wr_ok && paddr == 12'h270 |-> ##2 speed_bkpt_2[0] == $past(pwdata[30], 2))
    else $error("speed breakpoint two low bit wrong");
  a_toff_scale: assert property (1'b1 |=> turnoff_speed_hz_1 == 14'((22'($past(turnoff_target_1)) * 22'($past(max_speed_hz))) / 22'h0000ff))
    else $error("turn-off speed scaling wrong");
  a_sbk2_scale: assert property (1'b1 |=> bkpt_speed_hz_2 == 14'((22'($past(speed_bkpt_2)) * 22'($past(max_speed_hz))) / 22'h0000ff))
    else $error("breakpoint two speed scaling wrong");
  c_write: cover property (wr_ok);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_refused: cover property (pslverr);
endmodule

bind spcr_regs spcr_regs_asserts u_chk (
  .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
  .pslverr, .profile_mode, .profile_mode_sel, .input_on_threshold_1,
  .input_clamp_threshold_2, .turnoff_target_1, .speed_bkpt_2, .max_speed_hz,
  .turnoff_speed_hz_1, .bkpt_speed_hz_2
);

// >>> sim/spcr_regs_tb.sv
// testbench: apb access and joined field outputs of the speed profile bank
`timescale 1ns/100ps
module spcr_regs_tb;
  import spcr_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr;
  logic [31:0] prdata;
  spcr_mode_t profile_mode;
  logic [3:0] profile_mode_sel;
  logic [7:0] input_on_threshold_1, input_off_threshold_1, input_clamp_threshold_1;
  logic [7:0] input_on_threshold_2, input_off_threshold_2, input_clamp_threshold_2;
  logic [7:0] input_bkpt_1, input_bkpt_2, input_bkpt_3, input_bkpt_4, input_bkpt_5;
  logic [7:0] turnoff_target_1, clamp_target_1, speed_bkpt_1, speed_bkpt_2;
  logic [13:0] max_speed_hz, turnoff_speed_hz_1, clamp_speed_hz_1;
  logic [13:0] bkpt_speed_hz_1, bkpt_speed_hz_2;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [9:0] idx [6] = '{SPCR_IDX_LIMIT, SPCR_IDX_W1, SPCR_IDX_W2, SPCR_IDX_W3,
    SPCR_IDX_W4, SPCR_IDX_W5};
  logic [31:0] w [6];

  spcr_regs uut (
    .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .profile_mode, .profile_mode_sel, .input_on_threshold_1,
    .input_off_threshold_1, .input_clamp_threshold_1, .input_on_threshold_2,
    .input_off_threshold_2, .input_clamp_threshold_2, .input_bkpt_1, .input_bkpt_2,
    .input_bkpt_3, .input_bkpt_4, .input_bkpt_5, .turnoff_target_1, .clamp_target_1,
    .speed_bkpt_1, .speed_bkpt_2, .max_speed_hz, .turnoff_speed_hz_1,
    .clamp_speed_hz_1, .bkpt_speed_hz_1, .bkpt_speed_hz_2
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one idle cycle before each setup keeps a signal from being driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 32'(n < 50), 32'h1);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
  endtask

  function automatic logic [31:0] hz(input logic [7:0] v);
    return 32'((22'(v) * 22'(w[0][13:0])) / 22'h0000ff);
  endfunction
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, {idx[k], 2'h0}, 32'h0, 4'h0, r, e);
      chk("reset word", r, 32'h0);
    end
    chk("reset mode sel", 32'(profile_mode_sel), 32'h1);
  endtask

  task automatic t_fields(input logic [31:0] b);
    logic [31:0] r;
    logic e;
    for (int k = 0; k < 6; k++) begin
      w[k] = b ^ (32'h0123_4567 * k);
      apb(1'b1, {idx[k], 2'h0}, w[k], 4'hf, r, e);
    end
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, {idx[k], 2'h0}, 32'h0, 4'h0, r, e);
      chk("word readback", r, w[k]);
    end
    repeat (4) @(posedge clk);
    chk("mode", 32'(profile_mode), 32'(w[1][30:29]));
    chk("on1", 32'(input_on_threshold_1), 32'(w[1][28:21]));
    chk("off1", 32'(input_off_threshold_1), 32'(w[1][20:13]));
    chk("clamp1", 32'(input_clamp_threshold_1), 32'(w[1][12:5]));
    chk("bkpt1", 32'(input_bkpt_1), 32'({w[1][4:0], w[2][30:28]}));
    chk("bkpt2", 32'(input_bkpt_2), 32'(w[2][27:20]));
    chk("bkpt3", 32'(input_bkpt_3), 32'(w[2][19:12]));
    chk("bkpt4", 32'(input_bkpt_4), 32'(w[2][11:4]));
    chk("bkpt5", 32'(input_bkpt_5), 32'({w[2][3:0], w[3][30:27]}));
    chk("on2", 32'(input_on_threshold_2), 32'(w[3][26:19]));
    chk("off2", 32'(input_off_threshold_2), 32'(w[3][18:11]));
    chk("clamp2", 32'(input_clamp_threshold_2), 32'(w[3][10:3]));
    chk("toff", 32'(turnoff_target_1), 32'(w[4][30:23]));
    chk("tclamp", 32'(clamp_target_1), 32'(w[4][22:15]));
    chk("sbk1", 32'(speed_bkpt_1), 32'(w[4][14:7]));
    chk("sbk2", 32'(speed_bkpt_2), 32'({w[4][6:0], w[5][30]}));
    chk("max speed", 32'(max_speed_hz), 32'(w[0][13:0]));
    chk("toff hz", 32'(turnoff_speed_hz_1), hz(w[4][30:23]));
    chk("tclamp hz", 32'(clamp_speed_hz_1), hz(w[4][22:15]));
    chk("sbk1 hz", 32'(bkpt_speed_hz_1), hz(w[4][14:7]));
    chk("sbk2 hz", 32'(bkpt_speed_hz_2), hz({w[4][6:0], w[5][30]}));
  endtask

  task automatic t_bad();
    logic [31:0] r;
    logic e;
    apb(1'b1, 12'h254, 32'hffff_ffff, 4'hf, r, e);
    chk("unmapped error", 32'(e), 32'h1);
    apb(1'b1, 12'h252, 32'h1234_5678, 4'hf, r, e);
    chk("misaligned error", 32'(e), 32'h1);
    apb(1'b0, 12'h25a, 32'h0, 4'h0, r, e);
    chk("misaligned read data", r, 32'h0);
    apb(1'b0, 12'h250, 32'h0, 4'h0, r, e);
    chk("word one untouched", r, w[1]);
  endtask

  task automatic t_modes();
    logic [31:0] r;
    logic e;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h250, {1'b0, 2'(m), 29'h0}, 4'hf, r, e);
      repeat (4) @(posedge clk);
      chk("mode code", 32'(profile_mode), 32'(m));
      chk("mode sel", 32'(profile_mode_sel), 32'h1 << m);
    end
  endtask

  task automatic t_strobe();
    logic [31:0] r;
    logic e;
    apb(1'b1, 12'h268, 32'hffff_ffff, 4'hf, r, e);
    apb(1'b1, 12'h268, 32'h0000_0000, 4'h5, r, e);
    apb(1'b0, 12'h268, 32'h0, 4'h0, r, e);
    chk("byte strobes", r, 32'hff00_ff00);
    repeat (4) @(posedge clk);
    chk("sbk2 upper", 32'(speed_bkpt_2[7:1]), 32'h0);
  endtask
  // ****************************************************************
  // clock, timeout and main sequence
  // ****************************************************************
  initial begin
    forever #10 clk = ~clk;
  end

  // the whole run needs a few hundred cycles; this ceiling only catches a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    do_reset();
    t_reset();
    t_fields(32'hffff_ffff);
    t_fields(32'h5a3c_96e1);
    t_bad();
    t_modes();
    t_strobe();
    do_reset();
    t_reset();
    test_done();
  end
endmodule
